// File: hw/pci_config_header_bank.sv
// Overview of operation
// - With I/O enable clear, every I/O access and socket I/O window is ignored.
// - With I/O enable set, claim base range and enabled socket I/O windows.
// - Memory transactions and memory windows answer only with memory enable set.
// - Parity enable gates all parity checking and reporting except the detected flag.
// - Command bit 7 always reads one, advertising address stepping.
// - System error pin fires on address parity error if both enables are set.
// - Only detected address parity errors ever drive the system error pin.
// - System-error-generated flag sets only when this device fires the pin.
// - Parity-detected flag sets on any address or data parity error, always.
// - Master data parity flag is reserved and reads zero.
// - Device select timing field always reads binary 10, slow decode.
// - Class code field always reads the fixed bridge class value.
// - Revision field reports the silicon revision byte from the operation registers.
// - First word returns fixed vendor code low and device code high.
// - Configuration bank spans offsets 00 to 3F and serves the whole chip.
`default_nettype none
`include "cfg_bank_consts.svh"

module pci_config_header_bank
  import cfg_bank_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h0abc, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0def  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_sel,
  input  wire logic        cfg_wr,
  input  wire logic [5:0]  cfg_index,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output var  logic [31:0] cfg_rdata_q,
  output var  logic        cfg_rvalid_q,
  input  wire logic [7:0]  silicon_rev,
  input  wire logic        req_valid,
  input  wire space_t      req_space,
  input  wire logic        req_in_base,
  input  wire logic        req_in_io_win,
  input  wire logic        req_in_mem_win,
  output var  logic        claim_q,
  input  wire logic        addr_par_err,
  input  wire logic        data_par_err,
  output var  logic        serr_oe_q,
  output var  logic        perr_report_q,
  output var  logic        io_space_en_q,
  output var  logic        mem_space_en_q
);
  // ----------------------------------------
  // Writable command bits
  // ----------------------------------------
  logic par_en_q;
  logic serr_en_q;
  logic serr_flag_q;
  logic perr_flag_q;
  logic serr_fire;
  logic cmd_wr;
  logic stat_clr_serr;
  logic stat_clr_perr;
  logic [31:0] cmd_stat_word;
  logic [31:0] rdata_d;

  // Config cycles are decoded by the bus core; only indices inside the header land here
  assign cmd_wr = cfg_sel && cfg_wr && (cfg_index == `CFG_OFS_CMD_STAT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_space_en_q  <= 1'b0;
      mem_space_en_q <= 1'b0;
      par_en_q       <= 1'b0;
      serr_en_q      <= 1'b0;
    end else if (cmd_wr) begin
      // Only the enable bits are stored; bits 7 and reserved bits are not
      if (cfg_be[0]) begin
        io_space_en_q  <= cfg_wdata[`CMD_IO_EN_BIT];
        mem_space_en_q <= cfg_wdata[`CMD_MEM_EN_BIT];
        par_en_q       <= cfg_wdata[`CMD_PAR_EN_BIT];
      end
      if (cfg_be[1]) begin
        serr_en_q <= cfg_wdata[`CMD_SERR_EN_BIT];
      end
    end
  end

  // ----------------------------------------
  // Error detection and system error pin
  // ----------------------------------------
  assign serr_fire = addr_par_err && par_en_q && serr_en_q;

  serr_pulse u_serr (
    .clk       (clk),
    .rst_n     (rst_n),
    .fire      (serr_fire),
    .serr_oe_q (serr_oe_q)
  );

  // Data parity reporting is suppressed entirely when checking is off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      perr_report_q <= 1'b0;
    end else begin
      perr_report_q <= data_par_err && par_en_q;
    end
  end

  // ----------------------------------------
  // Sticky status flags, write one to clear
  // ----------------------------------------
  assign stat_clr_serr = cmd_wr && cfg_be[3] && cfg_wdata[`STAT_SERR_BIT];
  assign stat_clr_perr = cmd_wr && cfg_be[3] && cfg_wdata[`STAT_PERR_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serr_flag_q <= 1'b0;
    end else if (serr_fire) begin
      serr_flag_q <= 1'b1;
    end else if (stat_clr_serr) begin
      serr_flag_q <= 1'b0;
    end
  end

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      perr_flag_q <= 1'b0;
    end else if (addr_par_err || data_par_err) begin
      perr_flag_q <= 1'b1;
    end else if (stat_clr_perr) begin
      perr_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Target claim gating
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      claim_q <= 1'b0;
    end else if (!req_valid) begin
      claim_q <= 1'b0;
    end else begin
      case (req_space)
        SPACE_IO:  claim_q <= io_space_en_q && (req_in_base || req_in_io_win);
        SPACE_MEM: claim_q <= mem_space_en_q && req_in_mem_win;
        default:   claim_q <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    cmd_stat_word = `WORD_ZERO;
    cmd_stat_word[`CMD_IO_EN_BIT]   = io_space_en_q;
    cmd_stat_word[`CMD_MEM_EN_BIT]  = mem_space_en_q;
    cmd_stat_word[`CMD_PAR_EN_BIT]  = par_en_q;
    cmd_stat_word[`CMD_STEP_BIT]    = 1'b1;
    cmd_stat_word[`CMD_SERR_EN_BIT] = serr_en_q;
    cmd_stat_word[`STAT_MDPE_BIT]   = 1'b0;
    cmd_stat_word[`STAT_DEVSEL_HI:`STAT_DEVSEL_LO] = `DEVSEL_SLOW;
    // Bits 29-27 read zero; software must not rely on them
    cmd_stat_word[`STAT_SERR_BIT]   = serr_flag_q;
    cmd_stat_word[`STAT_PERR_BIT]   = perr_flag_q;
  end

  always_comb begin
    case (cfg_index)
      `CFG_OFS_IDENT:     rdata_d = {DEVICE_CODE, VENDOR_CODE};
      `CFG_OFS_CMD_STAT:  rdata_d = cmd_stat_word;
      `CFG_OFS_REV_CLASS: rdata_d = {`CLASS_BRIDGE, silicon_rev};
      default:            rdata_d = `WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q  <= `WORD_ZERO;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_sel && !cfg_wr;
      cfg_rdata_q  <= (cfg_sel && !cfg_wr) ? rdata_d : `WORD_ZERO;
    end
  end
endmodule
`default_nettype wire

// File: hw/serr_pulse.sv
`default_nettype none
// ----------------------------------------
// Register a one-cycle error event, unstretched and one cycle later, onto the open-drain system error pin
// ----------------------------------------
module serr_pulse (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fire,
  output var  logic serr_oe_q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serr_oe_q <= 1'b0;
    end else begin
      serr_oe_q <= fire;
    end
  end
endmodule
`default_nettype wire

// File: inc/cfg_bank_consts.svh
`ifndef CFG_BANK_CONSTS_SVH
`define CFG_BANK_CONSTS_SVH
// ----------------------------------------
// Configuration space layout
// ----------------------------------------
`define CFG_OFS_IDENT       6'h00
`define CFG_OFS_CMD_STAT    6'h01
`define CFG_OFS_REV_CLASS   6'h02
`define CFG_IDX_LAST        6'h0f
// ----------------------------------------
// Command and status bit positions
// ----------------------------------------
`define CMD_IO_EN_BIT       0
`define CMD_MEM_EN_BIT      1
`define CMD_PAR_EN_BIT      6
`define CMD_STEP_BIT        7
`define CMD_SERR_EN_BIT     8
`define STAT_MDPE_BIT       24
`define STAT_DEVSEL_LO      25
`define STAT_DEVSEL_HI      26
`define STAT_SERR_BIT       30
`define STAT_PERR_BIT       31
// ----------------------------------------
// Fixed field values
// ----------------------------------------
`define DEVSEL_SLOW         2'h2
`define CLASS_BRIDGE        24'h060500
`define WORD_ZERO           32'h0000_0000
`endif

// File: inc/cfg_bank_pkg.sv
`default_nettype none
package cfg_bank_pkg;
  typedef enum logic [1:0] {
    SPACE_CFG,
    SPACE_IO,
    SPACE_MEM
  } space_t;
endpackage
`default_nettype wire

// File: test/cfg_bank_assertions.sv
`default_nettype none
module cfg_bank_assertions
  import cfg_bank_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h0abc,
  parameter logic [15:0] DEVICE_CODE = 16'h0def
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cfg_sel,
  input wire logic        cfg_wr,
  input wire logic [5:0]  cfg_index,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_rvalid_q,
  input wire logic [7:0]  silicon_rev,
  input wire logic        req_valid,
  input wire space_t      req_space,
  input wire logic        req_in_base,
  input wire logic        req_in_io_win,
  input wire logic        req_in_mem_win,
  input wire logic        claim_q,
  input wire logic        addr_par_err,
  input wire logic        data_par_err,
  input wire logic        serr_oe_q,
  input wire logic        perr_report_q,
  input wire logic        io_space_en_q,
  input wire logic        mem_space_en_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_io_gate: assert property (req_valid && req_space == SPACE_IO && !io_space_en_q |=> !claim_q)
    else $error("io claim while disabled");
  chk_io_claim: assert property (req_valid && req_space == SPACE_IO && io_space_en_q && (req_in_base || req_in_io_win)
    |=> claim_q) else $error("io hit not claimed");
  chk_mem_claim: assert property (req_valid && req_space != SPACE_IO
    |=> claim_q == $past(req_space == SPACE_MEM && mem_space_en_q && req_in_mem_win)) else $error("bad mem claim");
  chk_serr_cause: assert property (serr_oe_q |-> $past(addr_par_err)) else $error("serr without cause");
  chk_perr_cause: assert property (perr_report_q |-> $past(data_par_err)) else $error("perr without cause");
  chk_cmd_fixed: assert property (cfg_rvalid_q && $past(cfg_index) == 6'h01
    |-> cfg_rdata_q[7] && cfg_rdata_q[26:24] == 3'b100) else $error("fixed command bits wrong");
  chk_ident_word: assert property (cfg_rvalid_q && $past(cfg_index) == 6'h00
    |-> cfg_rdata_q == {DEVICE_CODE, VENDOR_CODE}) else $error("ident word wrong");
  chk_class_rev: assert property (cfg_rvalid_q && $past(cfg_index) == 6'h02
    |-> cfg_rdata_q == {24'h060500, $past(silicon_rev)}) else $error("class word wrong");
  chk_read_answer: assert property (cfg_sel && !cfg_wr |=> cfg_rvalid_q) else $error("read not answered");
  cov_serr: cover property (serr_oe_q);
  cov_claim: cover property (claim_q);
  cov_perr: cover property (perr_report_q);
endmodule
bind pci_config_header_bank cfg_bank_assertions #(.VENDOR_CODE(VENDOR_CODE), .DEVICE_CODE(DEVICE_CODE)) u_chk (
  .clk, .rst_n, .cfg_sel, .cfg_wr, .cfg_index, .cfg_rdata_q, .cfg_rvalid_q, .silicon_rev, .req_valid,
  .req_space, .req_in_base, .req_in_io_win, .req_in_mem_win, .claim_q, .addr_par_err, .data_par_err,
  .serr_oe_q, .perr_report_q, .io_space_en_q, .mem_space_en_q);
`default_nettype wire

// File: test/cfg_host_model.sv
`default_nettype none
module cfg_host_model (
  input  wire logic        clk,
  output var  logic        cfg_sel,
  output var  logic        cfg_wr,
  output var  logic [5:0]  cfg_index,
  output var  logic [3:0]  cfg_be,
  output var  logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cfg_sel, cfg_wr, cfg_index, cfg_be, cfg_wdata} = '0;
  task acc(input logic w, input logic [5:0] i, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    {cfg_sel, cfg_wr, cfg_index, cfg_be} = {1'b1, w, i, b};
    cfg_wdata = d & 32'hc7ff_ffff;
    @(negedge clk);
    cfg_sel = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/pci_config_header_bank_test.sv
`default_nettype none
module pci_config_header_bank_test;
  import cfg_bank_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, cfg_sel, cfg_wr, req_valid = 0, req_in_base = 0, req_in_io_win = 0, req_in_mem_win = 0;
  logic addr_par_err = 0, data_par_err = 0, cfg_rvalid_q, claim_q, serr_oe_q, perr_report_q;
  logic io_space_en_q, mem_space_en_q;
  logic [5:0] cfg_index;
  logic [3:0] cfg_be;
  logic [7:0] silicon_rev = 8'h00;
  logic [31:0] cfg_wdata, cfg_rdata_q, exp_q[$];
  space_t req_space = SPACE_CFG;
  int err_count = 0, n_checks = 0;
  always #50 clk = ~clk;
  cfg_host_model u_host (.clk, .cfg_sel, .cfg_wr, .cfg_index, .cfg_be, .cfg_wdata);
  pci_config_header_bank #(.VENDOR_CODE(16'h0abc), .DEVICE_CODE(16'h0def)) u_dut (.clk, .rst_n, .cfg_sel, .cfg_wr,
    .cfg_index, .cfg_be, .cfg_wdata, .cfg_rdata_q, .cfg_rvalid_q, .silicon_rev, .req_valid, .req_space, .req_in_base,
    .req_in_io_win, .req_in_mem_win, .claim_q, .addr_par_err, .data_par_err, .serr_oe_q, .perr_report_q,
    .io_space_en_q, .mem_space_en_q);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [5:0] i, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.acc(1'b0, i, 4'h0, 32'h0);
  endtask
  task ev(input logic a, input logic d, input logic [1:0] e);
    @(negedge clk);
    {addr_par_err, data_par_err} = {a, d};
    @(negedge clk);
    {addr_par_err, data_par_err} = 2'b00;
    chk({30'h0, serr_oe_q, perr_report_q}, {30'h0, e});
  endtask
  task claims;
    repeat (30) begin
      @(negedge clk);
      req_space = space_t'($urandom_range(2));
      {req_valid, req_in_base, req_in_io_win, req_in_mem_win} = 4'($urandom);
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task stop_test;
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clk) if (cfg_rvalid_q === 1'b1) chk(cfg_rdata_q, exp_q.pop_front());
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h5481b74d));
    silicon_rev = 8'($urandom);
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rd(6'h00, 32'h0def_0abc);
    rd(6'h01, 32'h0400_0080);
    rd(6'h02, {24'h060500, silicon_rev});
    rd(6'h0f, 32'h0);
    claims;
    u_host.acc(1'b1, 6'h01, 4'hf, 32'hffff_ffff);
    rd(6'h01, 32'h0400_01c3);
    claims;
    ev(1'b1, 1'b0, 2'b10);
    rd(6'h01, 32'hc400_01c3);
    ev(1'b0, 1'b1, 2'b01);
    u_host.acc(1'b1, 6'h01, 4'h8, 32'hc000_0000);
    rd(6'h01, 32'h0400_01c3);
    u_host.acc(1'b1, 6'h01, 4'h1, 32'h0000_0003);
    ev(1'b1, 1'b1, 2'b00);
    rd(6'h01, 32'h8400_0183);
    repeat (2) @(negedge clk);
    chk(32'(exp_q.size()), 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
